/* File: hdl/sisp_consts.svh */
// constants for the sensor i2c slave port
// assumes inclusion by the package and the design module only
`ifndef SISP_CONSTS_SVH
`define SISP_CONSTS_SVH
`define SISP_ADDR_BASE   7'h6A
`define SISP_ADDR_W      7
`define SISP_RADDR_W     7
`define SISP_INC_BIT     7
`define SISP_BIT_LAST    3'h7
`define SISP_STD_KHZ     100
`define SISP_FAST_KHZ    400
`define SISP_MCLK_MHZ    200
`endif

/* File: hdl/sisp_pkg.sv */
// types for the sensor i2c slave port
// assumes sisp_consts.svh sits beside it
`default_nettype none
`include "sisp_consts.svh"
package sisp_pkg;
  // register-side access strobe with its data
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } sisp_acc_s;
  // bus-side state, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_AACK = 6'b00_0100,
    ST_WBYT = 6'b00_1000,
    ST_RBYT = 6'b01_0000,
    ST_RACK = 6'b10_0000
  } sisp_st_e;
endpackage : sisp_pkg
`default_nettype wire

/* File: hdl/sisp_slave.sv */
// i2c slave port giving a host access to the configuration registers
// assumes scl and sda come from pins and are synchronised here;
// the register file answers reads combinationally on REG_RDATA
`default_nettype none
`include "sisp_consts.svh"
module sisp_slave
  import sisp_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RESET,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  input  wire logic       ADDR_LSB_SELECT_PIN,
  output var  logic       SDA_OUT,
  output var  logic       SDA_OE,
  output var  logic       REG_WR,
  output var  logic       REG_RD,
  output var  logic [6:0] REG_ADDR,
  output var  logic [7:0] REG_WDATA,
  input  wire logic [7:0] REG_RDATA
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  // two stages each; the first stage feeds only the second
  logic [1:0] scl_sy_ff, sda_sy_ff, sel_sy_ff;
  logic       scl_d_ff, sda_d_ff;
  always_ff @(posedge MCLK or posedge RESET)
    if (RESET)
    begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      sel_sy_ff <= 2'h0;
      scl_d_ff  <= 1'b1;
      sda_d_ff  <= 1'b1;
    end
    else
    begin
      scl_sy_ff <= {scl_sy_ff[0], SCL_IN};
      sda_sy_ff <= {sda_sy_ff[0], SDA_IN};
      sel_sy_ff <= {sel_sy_ff[0], ADDR_LSB_SELECT_PIN};
      scl_d_ff  <= scl_sy_ff[1];
      sda_d_ff  <= sda_sy_ff[1];
    end

  // edge and condition detection on the synchronised lines
  // oversampling by mclk
  // 200 MHz gives 260 samples of the shortest 1300 ns low phase
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
  assign scl_s    = scl_sy_ff[1];
  assign sda_s    = sda_sy_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // own address follows the select pin
  logic [6:0] own_addr;
  assign own_addr = `SISP_ADDR_BASE | {6'h00, sel_sy_ff[1]};   // base has bit 0 clear

  // ==========================================================
  // protocol state
  // ==========================================================
  sisp_st_e   st_ff, nxt_st;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic       rw_ff, nxt_rw;
  logic       first_ff, nxt_first;   // next written byte is register address
  logic       inc_ff, nxt_inc;
  logic       nack_ff, nxt_nack;     // master refused a read byte
  logic       drv_ff, nxt_drv;       // pull sda low after next fall
  logic       oe_ff, nxt_oe;
  sisp_acc_s  acc_ff, nxt_acc;

  // next-state computation; sda changes only on scl fall
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_bit   = bit_ff;
    nxt_sh    = sh_ff;
    nxt_rw    = rw_ff;
    nxt_first = first_ff;
    nxt_inc   = inc_ff;
    nxt_nack  = nack_ff;
    nxt_drv   = drv_ff;
    nxt_oe    = oe_ff;
    nxt_acc   = acc_ff;
    nxt_acc.wr = 1'b0;
    nxt_acc.rd = 1'b0;
    if (start_c)
    begin
      // repeated start keeps register address for a read-back
      nxt_st  = ST_ADDR;
      nxt_bit = 3'h0;
      nxt_oe  = 1'b0;
      nxt_drv = 1'b0;
    end
    else if (stop_c)
    begin
      nxt_st = ST_IDLE;
      nxt_oe = 1'b0;
    end
    else
    begin
      case (st_ff)
        ST_IDLE: nxt_oe = 1'b0;
        ST_ADDR, ST_WBYT:
        begin
          if (scl_fall)
            nxt_oe = 1'b0;
          if (scl_rise)
          begin
            nxt_sh  = {sh_ff[6:0], sda_s};
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == `SISP_BIT_LAST)
            begin
              if (st_ff == ST_ADDR)
              begin
                if (sh_ff[6:0] == own_addr)
                begin
                  nxt_st    = ST_AACK;
                  nxt_rw    = sda_s;
                  nxt_drv   = 1'b1;
                  nxt_first = ~sda_s;
                end
                else
                  nxt_st = ST_IDLE;
              end
              else if (first_ff)
              begin
                // top bit is the increment flag
                nxt_inc      = sh_ff[`SISP_INC_BIT - 1];
                nxt_acc.addr = {sh_ff[5:0], sda_s};
                nxt_first    = 1'b0;
                nxt_st       = ST_AACK;
                nxt_drv      = 1'b1;
              end
              else
              begin
                nxt_acc.wr   = 1'b1;
                nxt_acc.data = {sh_ff[6:0], sda_s};
                nxt_st       = ST_AACK;
                nxt_drv      = 1'b1;
              end
            end
          end
        end
        ST_AACK:
        begin
          // ack held low for the ninth clock
          if (scl_fall && drv_ff)
          begin
            nxt_oe  = 1'b1;
            nxt_drv = 1'b0;
          end
          else if (scl_fall)
          begin
            nxt_bit = 3'h0;
            if (rw_ff)
            begin
              // register read, first bit driven now
              nxt_acc.rd = 1'b1;
              nxt_sh     = REG_RDATA;
              nxt_oe     = ~REG_RDATA[7];
              nxt_st     = ST_RBYT;
            end
            else
            begin
              nxt_oe = 1'b0;
              nxt_st = ST_WBYT;
            end
          end
        end
        ST_RBYT:
        begin
          if (scl_rise)
            nxt_bit = bit_ff + 3'h1;
          if (scl_fall)
          begin
            if (bit_ff == 3'h0)
            begin
              nxt_oe = 1'b0;
              nxt_st = ST_RACK;
            end
            else
              nxt_oe = ~sh_ff[`SISP_BIT_LAST - bit_ff];
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            nxt_nack = sda_s;
          // master ack: next byte's top bit goes out at this fall
          if (scl_fall && !nack_ff)
          begin
            nxt_bit    = 3'h0;
            nxt_acc.rd = 1'b1;
            nxt_sh     = REG_RDATA;
            nxt_oe     = ~REG_RDATA[7];
            nxt_st     = ST_RBYT;
          end
          else if (scl_fall)
            nxt_st = ST_IDLE;
        end
        default: nxt_st = ST_IDLE;
      endcase
      // step address after each data byte
      if (inc_ff && (acc_ff.wr || acc_ff.rd))
        nxt_acc.addr = acc_ff.addr + 7'h01;
    end
  end

  // registers only
  always_ff @(posedge MCLK or posedge RESET)
    if (RESET)
    begin
      st_ff    <= ST_IDLE;
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      rw_ff    <= 1'b0;
      first_ff <= 1'b0;
      inc_ff   <= 1'b0;
      nack_ff  <= 1'b0;
      drv_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      acc_ff   <= '0;
    end
    else
    begin
      st_ff    <= nxt_st;
      bit_ff   <= nxt_bit;
      sh_ff    <= nxt_sh;
      rw_ff    <= nxt_rw;
      first_ff <= nxt_first;
      inc_ff   <= nxt_inc;
      nack_ff  <= nxt_nack;
      drv_ff   <= nxt_drv;
      oe_ff    <= nxt_oe;
      acc_ff   <= nxt_acc;
    end

  // outputs straight from flip-flops; open drain so data is always 0
  assign SDA_OUT   = 1'b0;
  assign SDA_OE    = oe_ff;
  assign REG_WR    = acc_ff.wr;
  assign REG_RD    = acc_ff.rd;
  assign REG_ADDR  = acc_ff.addr;
  assign REG_WDATA = acc_ff.data;

  // ==========================================================
  // assertions
  // ==========================================================
  // no ack unless the address matched
  ack_needs_match_a: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(st_ff == ST_AACK) && $past(st_ff) == ST_ADDR |-> $past(sh_ff[6:0]) == own_addr)
    else $error("ack without address match");
  // own address for either select level gets an ack
  own_addr_lsb_a: assert property (@(posedge MCLK) disable iff (RESET)
    st_ff == ST_ADDR && scl_rise && bit_ff == `SISP_BIT_LAST
    && sh_ff[6:0] == (`SISP_ADDR_BASE | {6'h00, sel_sy_ff[1]}) |=> st_ff == ST_AACK)
    else $error("own address not acknowledged");
  idle_release_a: assert property (@(posedge MCLK) disable iff (RESET)
    st_ff == ST_IDLE && $past(st_ff) == ST_IDLE |-> !oe_ff)
    else $error("sda driven while idle");
  addr_step_a: assert property (@(posedge MCLK) disable iff (RESET)
    acc_ff.wr && inc_ff && !start_c && !stop_c |=> acc_ff.addr == $past(acc_ff.addr) + 7'h01)
    else $error("address not incremented");
  strobe_pulse_a: assert property (@(posedge MCLK) disable iff (RESET)
    acc_ff.wr |=> !acc_ff.wr)
    else $error("write strobe too long");
  stop_idle_a: assert property (@(posedge MCLK) disable iff (RESET)
    stop_c && !start_c |=> st_ff == ST_IDLE && !oe_ff)
    else $error("stop not honoured");
  write_seen_c: cover property (@(posedge MCLK) disable iff (RESET) acc_ff.wr);
  read_seen_c: cover property (@(posedge MCLK) disable iff (RESET) acc_ff.rd);
  inc_seen_c: cover property (@(posedge MCLK) disable iff (RESET) acc_ff.wr && inc_ff);
endmodule : sisp_slave
`default_nettype wire

/* File: testbench/sisp_host_model.sv */
// i2c bus master standing in for the host processor
// assumes the bench resolves sda as open drain with a pull-up
`default_nettype none
module sisp_host_model
(
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter of the scl period: 125 ns link clock by default
  // the bench stretches it to check the fast-mode rate
  realtime q = 31.25;
  // idle bus: scl stands high, sda released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ==========================================
  // bit level
  // sda moves mid low, is sampled mid high
  task automatic bit_xfer(input logic b, output logic r);
    #q sda_low = ~b;
    #q scl = 1'b1;
    #q r = sda;
    #q scl = 1'b0;
  endtask : bit_xfer
  // works from idle and as a repeated start
  task automatic start();
    #q sda_low = 1'b0;
    #q scl = 1'b1;
    #q sda_low = 1'b1;
    #q scl = 1'b0;
  endtask : start
  // clock left standing high afterwards
  task automatic stop();
    #q sda_low = 1'b1;
    #q scl = 1'b1;
    #q sda_low = 1'b0;
    #q;
  endtask : stop
  // ==========================================
  // byte level
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // last byte gets a nack so the slave lets go
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, d[i]);
    bit_xfer(last, r);
  endtask : rd_byte
  task automatic address(input logic [6:0] a, input logic rd, output logic ack);
    start();
    wr_byte({a, rd}, ack);
  endtask : address
endmodule : sisp_host_model
`default_nettype wire

/* File: testbench/sisp_slave_tb.sv */
// self-checking bench for the i2c slave port
// assumes a combinational register file, modelled here
`default_nettype none
module sisp_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK = 1'b0;
  logic        RESET = 1'b1;
  logic        sel = 1'b0;
  logic        quiet = 1'b0;
  wire logic   scl, m_low, sda, sda_out, sda_oe, reg_wr, reg_rd;
  wire logic [6:0] reg_addr;
  wire logic [7:0] reg_wdata, reg_rdata;
  logic [7:0]  regs [128];
  logic [7:0]  exp_mem [128];
  logic [14:0] wq [$];
  logic [14:0] ew;
  logic [6:0]  rq [$];
  logic [15:0] er;
  logic [31:0] seed = 32'h0000_54bc;
  logic [31:0] r32;
  logic [6:0]  base;
  int          err_count = 0;
  int          check_count = 0;
  // 200 MHz clock
  always #2.5 MCLK = ~MCLK;
  // open drain wire with pull-up
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  assign reg_rdata = regs[reg_addr];
  sisp_slave i_sisp_slave (.MCLK(MCLK), .RESET(RESET), .SCL_IN(scl), .SDA_IN(sda),
    .ADDR_LSB_SELECT_PIN(sel), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));
  sisp_host_model i_sisp_host_model (.scl(scl), .sda_low(m_low), .sda(sda));
  // ==========================================
  // helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // register file, and every strobe against the model queues;
  // looked at mid-cycle, where the strobes have settled
  always @(negedge MCLK)
  begin
    if (reg_wr === 1'b1)
    begin
      regs[reg_addr] <= reg_wdata;
      ew = (wq.size() > 0) ? wq.pop_front() : 15'h7fff;
      check({1'b0, reg_addr, reg_wdata}, {1'b0, ew});
    end
    if (reg_rd === 1'b1)
    begin
      er = (rq.size() > 0) ? {9'h000, rq.pop_front()} : 16'hffff;
      check({9'h000, reg_addr}, er);
    end
    if (quiet && sda_oe !== 1'b0)
      check(sda_oe, 16'h0000);
  end
  // ==========================================
  // transfers
  task automatic wr_burst(input logic [6:0] dev, input logic inc, input logic [6:0] ra,
                          input int n, input logic hit);
    logic ack;
    logic [7:0] d;
    logic [6:0] a;
    a = ra;
    i_sisp_host_model.address(dev, 1'b0, ack);
    check(ack, hit);
    i_sisp_host_model.wr_byte({inc, ra}, ack);
    check(ack, hit);
    repeat (n)
    begin
      r32 = rnd();
      d = r32[7:0];
      if (hit)
      begin
        wq.push_back({a, d});
        exp_mem[a] = d;
      end
      i_sisp_host_model.wr_byte(d, ack);
      check(ack, hit);
      a = a + {6'h00, inc};
    end
    i_sisp_host_model.stop();
    repeat (20) @(negedge MCLK);
  endtask : wr_burst
  task automatic rd_burst(input logic [6:0] dev, input logic [6:0] ra, input int n);
    logic ack;
    logic [7:0] d;
    for (int i = 0; i < n; i++)
      rq.push_back(ra + i[6:0]);
    i_sisp_host_model.address(dev, 1'b0, ack);
    i_sisp_host_model.wr_byte({1'b1, ra}, ack);
    i_sisp_host_model.address(dev, 1'b1, ack);
    check(ack, 16'h0001);
    for (int i = 0; i < n; i++)
    begin
      i_sisp_host_model.rd_byte(i == n - 1, d);
      check(d, exp_mem[ra + i[6:0]]);
    end
    i_sisp_host_model.stop();
  endtask : rd_burst
  // ==========================================
  // main sequence
  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      regs[i] = i[7:0] ^ 8'h5a;
      exp_mem[i] = i[7:0] ^ 8'h5a;
    end
    repeat (4) @(negedge MCLK);
    check({sda_oe, reg_wr, reg_rd, reg_addr}, 16'h0000);
    RESET = 1'b0;
    repeat (4) @(negedge MCLK);
    for (int s = 0; s < 2; s++)
    begin
      sel = s[0];
      repeat (8) @(negedge MCLK);
      r32 = rnd();
      base = {1'b0, r32[5:0]};
      wr_burst(7'h6a | s[6:0], 1'b1, base, 3, 1'b1);
      wr_burst(7'h6a | s[6:0], 1'b0, base + 7'h08, 2, 1'b1);
      quiet = 1'b1;
      wr_burst(7'h6b ^ s[6:0], 1'b1, base, 2, 1'b0);
      quiet = 1'b0;
      rd_burst(7'h6a | s[6:0], base, 4);
      $display("test select %0d done", s);
    end
    // fast-mode rate, 2.5 us scl period, select still high
    i_sisp_host_model.q = 625.0;
    wr_burst(7'h6b, 1'b1, 7'h10, 1, 1'b1);
    rd_burst(7'h6b, 7'h10, 2);
    $display("test fast mode done");
    check(16'(wq.size() + rq.size()), 16'h0000);
    final_report();
  end
  // traffic needs about 250 us
  initial
  begin
    #400us;
    err_count++;
    final_report();
  end
endmodule : sisp_slave_tb
`default_nettype wire
